// File: design/dio_top.sv
// Drive I/O conditioning: run interlocks, first analogue input to frequency
// reference, and the function selector of the first relay output.
// Assumes field contacts are asynchronous, while converter samples, drive status
// and the register port come from logic on CLOCK.
`timescale 1ns/1ps
module dio_top (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic NRST,
  // Field contacts, high when closed.
  input wire logic RUN_INTERLOCK_FIRST,
  input wire logic RUN_INTERLOCK_SECOND,
  input wire logic RUN_PERMISSION_INPUT,
  // Converter samples of the first analogue input.
  input wire logic [dio_pkg::AI_W-1:0] FIRST_ANALOG_INPUT,
  input wire logic FIRST_ANALOG_VALID,
  // Drive control core.
  input wire dio_pkg::dio_status_t DRIVE_STATUS,
  input wire logic START_REQUEST,
  output logic START_GRANT,
  output logic START_PERMIT,
  output logic STOP_REQUEST,
  output logic COAST_STOP,
  output logic [dio_pkg::DATA_W-1:0] FREQ_REF,
  output logic FREQ_REF_VALID,
  // Relay drive.
  output logic FIRST_RELAY_OUTPUT,
  // Register port.
  input wire logic [dio_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [dio_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [dio_pkg::DATA_W-1:0] REG_RDATA
);
  typedef enum logic [1:0] {SC_IDLE, SC_DIVIDE, SC_OUTPUT} dio_scale_state_t;

  // Relay selector; unknown codes keep the relay off.
  function automatic logic relay_pick(input logic [5:0] sel,
                                      input dio_pkg::dio_status_t st,
                                      input logic at_speed);
    logic r;
    r = 1'b0;
    case (sel)
      dio_pkg::RLY_NOT_USED: r = 1'b0;
      dio_pkg::RLY_READY: r = st.ready;
      dio_pkg::RLY_RUN: r = st.running;
      dio_pkg::RLY_FAULT: r = st.fault;
      dio_pkg::RLY_FAULT_INV: r = !st.fault;
      dio_pkg::RLY_ALARM: r = st.alarm;
      dio_pkg::RLY_REVERSE: r = st.reverse;
      dio_pkg::RLY_AT_SPEED: r = at_speed;
      dio_pkg::RLY_THERMISTOR: r = st.thermistor;
      dio_pkg::RLY_LIMIT_REG: r = st.limit_active;
      dio_pkg::RLY_START: r = st.start_active;
      dio_pkg::RLY_KEYPAD: r = st.keypad_place;
      dio_pkg::RLY_PLACE_B: r = st.place_b;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Clamps a written custom point to the allowed signed span.
  function automatic logic [11:0] custom_clamp(input logic [dio_pkg::DATA_W-1:0] v);
    logic signed [15:0] s;
    logic [11:0] r;
    s = $signed(v);
    r = v[11:0];
    if (s > $signed({4'h0, dio_pkg::CUSTOM_LIMIT})) begin
      r = dio_pkg::CUSTOM_LIMIT;
    end else if (s < -$signed({4'h0, dio_pkg::CUSTOM_LIMIT})) begin
      r = 12'(-dio_pkg::CUSTOM_LIMIT);
    end
    return r;
  endfunction

  // Two-stage synchronisers on the contact pins.
  logic [2:0] pins_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  assign pins_raw = {RUN_PERMISSION_INPUT, RUN_INTERLOCK_SECOND, RUN_INTERLOCK_FIRST};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // Settings registers.
  logic [2:0] ctrl_reg;
  logic [dio_pkg::DATA_W-1:0] filter_time_reg;
  logic [11:0] custom_low_reg;
  logic [11:0] custom_high_reg;
  logic [dio_pkg::DATA_W-1:0] freq_min_reg;
  logic [dio_pkg::DATA_W-1:0] freq_max_reg;
  logic [5:0] relay_sel_reg;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= '0;
      filter_time_reg <= '0;
      custom_low_reg <= dio_pkg::CUSTOM_LOW_RST;
      custom_high_reg <= dio_pkg::CUSTOM_HIGH_RST;
      freq_min_reg <= dio_pkg::FREQ_MIN_RST;
      freq_max_reg <= dio_pkg::FREQ_MAX_RST;
      relay_sel_reg <= dio_pkg::RLY_NOT_USED;
    end else if (REG_WRITE) begin
      case (REG_ADDR)
        dio_pkg::REG_CTRL: ctrl_reg <= REG_WDATA[2:0];
        dio_pkg::REG_FILTER_TIME: filter_time_reg <= REG_WDATA;
        dio_pkg::REG_CUSTOM_LOW: custom_low_reg <= custom_clamp(REG_WDATA);
        dio_pkg::REG_CUSTOM_HIGH: custom_high_reg <= custom_clamp(REG_WDATA);
        dio_pkg::REG_FREQ_MIN: freq_min_reg <= REG_WDATA;
        dio_pkg::REG_FREQ_MAX: freq_max_reg <= REG_WDATA;
        dio_pkg::REG_RELAY_SEL: relay_sel_reg <= REG_WDATA[5:0];
        default: ;
      endcase
    end
  end

  // Start gating from the synchronised contacts.
  logic run_enable;
  logic interlocks_closed;
  logic permit;
  assign run_enable = sync2_reg[2];
  assign interlocks_closed = sync2_reg[0] && sync2_reg[1];
  assign permit = interlocks_closed && run_enable;

  logic start_grant_reg;
  logic start_permit_reg;
  logic stop_request_reg;
  logic coast_stop_reg;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      start_grant_reg <= 1'b0;
      start_permit_reg <= 1'b0;
      stop_request_reg <= 1'b0;
      coast_stop_reg <= 1'b0;
    end else begin
      start_permit_reg <= permit;
      start_grant_reg <= START_REQUEST && permit;
      stop_request_reg <= !run_enable;
      coast_stop_reg <= !run_enable && ctrl_reg[dio_pkg::CTRL_FOLLOWER_BIT];
    end
  end

  // Filter stage.
  logic [dio_pkg::AI_W-1:0] filtered;
  logic filtered_valid;

  dio_lowpass u_lowpass (
    .clk(CLOCK),
    .rst_n(NRST),
    .sample(FIRST_ANALOG_INPUT),
    .sample_valid(FIRST_ANALOG_VALID),
    .filter_time(filter_time_reg),
    .filtered(filtered),
    .filtered_valid(filtered_valid)
  );

  // Raw code to tenths of a percent of the selected range.
  logic [27:0] raw_product;
  logic [10:0] raw_pm;
  logic [10:0] live_pm;
  logic [10:0] range_pm;
  logic [13:0] live_prod;
  assign raw_product = filtered * dio_pkg::RAW_TO_PM_MUL;
  assign raw_pm = raw_product[dio_pkg::PM_SHIFT +: 11];
  assign live_prod = 14'(raw_pm - dio_pkg::LIVE_ZERO_PM) * 14'h0005;
  assign live_pm = (raw_pm <= dio_pkg::LIVE_ZERO_PM) ? '0 : live_prod[12:2];
  assign range_pm = ctrl_reg[dio_pkg::CTRL_RANGE_BIT] ? live_pm : raw_pm;

  // Custom window, signed comparisons.
  logic signed [12:0] p_s;
  logic signed [12:0] low_s;
  logic signed [12:0] high_s;
  logic [12:0] num_base;
  logic [12:0] den_full;
  assign p_s = $signed({2'b00, range_pm});
  assign low_s = $signed({custom_low_reg[11], custom_low_reg});
  assign high_s = $signed({custom_high_reg[11], custom_high_reg});
  assign num_base = 13'(p_s - low_s);
  assign den_full = 13'(high_s - low_s);

  // Scaling sequencer: clamp outside the window, divide inside it.
  dio_scale_state_t state_reg;
  logic [dio_pkg::PCT_W-1:0] pct_reg;
  logic div_start;
  logic div_done;
  logic [dio_pkg::NUM_W-1:0] div_quot;

  assign div_start = (state_reg == SC_IDLE) && filtered_valid && (high_s > low_s)
                     && (p_s > low_s) && (p_s < high_s);

  dio_divider u_divider (
    .clk(CLOCK),
    .rst_n(NRST),
    .start(div_start),
    .num({num_base[11:0], 10'h000}),
    .den(den_full[11:0]),
    .busy(),
    .done(div_done),
    .quot(div_quot)
  );

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= SC_IDLE;
      pct_reg <= '0;
    end else begin
      case (state_reg)
        SC_IDLE: begin
          if (div_start) begin
            state_reg <= SC_DIVIDE;
          end else if (filtered_valid) begin
            // A collapsed window reads as zero, as does anything at or under low.
            pct_reg <= (high_s > low_s && p_s >= high_s) ? dio_pkg::PCT_FULL : '0;
            state_reg <= SC_OUTPUT;
          end
        end
        SC_DIVIDE: begin
          if (div_done) begin
            pct_reg <= (div_quot > 22'(dio_pkg::PCT_FULL)) ? dio_pkg::PCT_FULL
                       : div_quot[dio_pkg::PCT_W-1:0];
            state_reg <= SC_OUTPUT;
          end
        end
        SC_OUTPUT: state_reg <= SC_IDLE;
        default: state_reg <= SC_IDLE;
      endcase
    end
  end

  // Frequency reference between the limits; an inverted span falls to minimum.
  logic [dio_pkg::PCT_W-1:0] pct_dir;
  logic [dio_pkg::DATA_W-1:0] span;
  logic [26:0] span_prod;
  logic [dio_pkg::DATA_W-1:0] freq_calc;
  assign pct_dir = ctrl_reg[dio_pkg::CTRL_INVERT_BIT]
                   ? dio_pkg::PCT_FULL - pct_reg
                   : pct_reg;
  assign span = (freq_max_reg > freq_min_reg) ? freq_max_reg - freq_min_reg : '0;
  assign span_prod = span * pct_dir;
  assign freq_calc = freq_min_reg + span_prod[dio_pkg::PCT_SHIFT +: dio_pkg::DATA_W];

  logic [dio_pkg::DATA_W-1:0] freq_ref_reg;
  logic freq_valid_reg;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      freq_ref_reg <= dio_pkg::FREQ_MIN_RST;
      freq_valid_reg <= 1'b0;
    end else begin
      freq_valid_reg <= (state_reg == SC_OUTPUT);
      if (state_reg == SC_OUTPUT) begin
        freq_ref_reg <= freq_calc;
      end
    end
  end

  // Relay output.
  logic [dio_pkg::DATA_W-1:0] freq_gap;
  logic at_speed;
  logic relay_reg;
  assign freq_gap = (DRIVE_STATUS.out_freq > DRIVE_STATUS.set_ref)
                    ? DRIVE_STATUS.out_freq - DRIVE_STATUS.set_ref
                    : DRIVE_STATUS.set_ref - DRIVE_STATUS.out_freq;
  assign at_speed = DRIVE_STATUS.running && (freq_gap <= dio_pkg::AT_SPEED_BAND);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relay_pick(relay_sel_reg, DRIVE_STATUS, at_speed);
    end
  end

  // Read port; unmapped indices read zero.
  logic [dio_pkg::DATA_W-1:0] rdata_reg;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rdata_reg <= '0;
    end else if (REG_READ) begin
      case (REG_ADDR)
        dio_pkg::REG_CTRL: rdata_reg <= {13'h0000, ctrl_reg};
        dio_pkg::REG_FILTER_TIME: rdata_reg <= filter_time_reg;
        dio_pkg::REG_CUSTOM_LOW: rdata_reg <= {{4{custom_low_reg[11]}}, custom_low_reg};
        dio_pkg::REG_CUSTOM_HIGH: rdata_reg <= {{4{custom_high_reg[11]}}, custom_high_reg};
        dio_pkg::REG_FREQ_MIN: rdata_reg <= freq_min_reg;
        dio_pkg::REG_FREQ_MAX: rdata_reg <= freq_max_reg;
        dio_pkg::REG_RELAY_SEL: rdata_reg <= {10'h000, relay_sel_reg};
        dio_pkg::REG_STATUS: rdata_reg <= {10'h000, coast_stop_reg, relay_reg,
                                           start_permit_reg, sync2_reg};
        dio_pkg::REG_AI_SCALED: rdata_reg <= {5'h00, pct_reg};
        dio_pkg::REG_FREQ_REF: rdata_reg <= freq_ref_reg;
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign START_GRANT = start_grant_reg;
  assign START_PERMIT = start_permit_reg;
  assign STOP_REQUEST = stop_request_reg;
  assign COAST_STOP = coast_stop_reg;
  assign FREQ_REF = freq_ref_reg;
  assign FREQ_REF_VALID = freq_valid_reg;
  assign FIRST_RELAY_OUTPUT = relay_reg;
  assign REG_RDATA = rdata_reg;
endmodule // dio_top

// File: design/dio_pkg.sv
// Shared constants and types of the drive I/O conditioning block.
// Assumes a 50 MHz system clock and one asynchronous active-low reset.
package dio_pkg;

  // Clock and filter timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_UNIT_NS = 10_000_000;
  localparam int FILTER_SHIFT = 8;
  localparam int PRESCALE_CYC = FILTER_UNIT_NS / CLK_PERIOD_NS / (1 << FILTER_SHIFT);
  localparam int PRESCALE_W = 11;

  // Widths.
  localparam int AI_W = 12;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int NUM_W = 22;
  localparam int PCT_W = 11;

  // Register indices.
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FILTER_TIME = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CUSTOM_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CUSTOM_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] REG_FREQ_MIN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FREQ_MAX = 4'h5;
  localparam logic [ADDR_W-1:0] REG_RELAY_SEL = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] REG_AI_SCALED = 4'h8;
  localparam logic [ADDR_W-1:0] REG_FREQ_REF = 4'h9;

  // Control register fields.
  localparam int CTRL_RANGE_BIT = 0;
  localparam int CTRL_INVERT_BIT = 1;
  localparam int CTRL_FOLLOWER_BIT = 2;

  // Reset values; custom points are signed tenths of a percent.
  localparam logic [11:0] CUSTOM_LOW_RST = 12'h000;
  localparam logic [11:0] CUSTOM_HIGH_RST = 12'h3E8;
  localparam logic [11:0] CUSTOM_LIMIT = 12'h640;
  localparam logic [DATA_W-1:0] FREQ_MIN_RST = 16'h0000;
  localparam logic [DATA_W-1:0] FREQ_MAX_RST = 16'h1388;

  // Scaling: raw code to tenths of a percent, live zero, unit of the scaled value.
  localparam logic [15:0] RAW_TO_PM_MUL = 16'h3E84;
  localparam int PM_SHIFT = 16;
  localparam logic [10:0] LIVE_ZERO_PM = 11'h0C8;
  localparam logic [10:0] FULL_PM = 11'h3E8;
  localparam int PCT_SHIFT = 10;
  localparam logic [PCT_W-1:0] PCT_FULL = 11'h400;
  localparam logic [DATA_W-1:0] AT_SPEED_BAND = 16'h000A;

  // Relay function codes.
  localparam logic [5:0] RLY_NOT_USED = 6'h00;
  localparam logic [5:0] RLY_READY = 6'h01;
  localparam logic [5:0] RLY_RUN = 6'h02;
  localparam logic [5:0] RLY_FAULT = 6'h03;
  localparam logic [5:0] RLY_FAULT_INV = 6'h04;
  localparam logic [5:0] RLY_ALARM = 6'h05;
  localparam logic [5:0] RLY_REVERSE = 6'h06;
  localparam logic [5:0] RLY_AT_SPEED = 6'h07;
  localparam logic [5:0] RLY_THERMISTOR = 6'h08;
  localparam logic [5:0] RLY_LIMIT_REG = 6'h09;
  localparam logic [5:0] RLY_START = 6'h0A;
  localparam logic [5:0] RLY_KEYPAD = 6'h0B;
  localparam logic [5:0] RLY_PLACE_B = 6'h0C;

  typedef struct packed {
    logic ready;
    logic running;
    logic fault;
    logic alarm;
    logic reverse;
    logic thermistor;
    logic limit_active;
    logic start_active;
    logic keypad_place;
    logic place_b;
    logic [DATA_W-1:0] out_freq;
    logic [DATA_W-1:0] set_ref;
  } dio_status_t;

endpackage

// File: design/dio_lowpass.sv
// First-order low-pass for the analogue input samples.
// Assumes samples arrive from same-clock converter logic with a one-cycle valid.
`timescale 1ns/1ps
module dio_lowpass (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Samples in.
  input wire logic [dio_pkg::AI_W-1:0] sample,
  input wire logic sample_valid,
  // Setting in units of 10 ms.
  input wire logic [dio_pkg::DATA_W-1:0] filter_time,
  // Filtered value.
  output logic [dio_pkg::AI_W-1:0] filtered,
  output logic filtered_valid
);
  logic [dio_pkg::AI_W-1:0] sample_reg;
  logic [dio_pkg::PRESCALE_W-1:0] pre_reg;
  logic [dio_pkg::DATA_W-1:0] unit_reg;
  logic [19:0] acc_reg;
  logic valid_reg;
  logic bypass;
  logic pre_end;
  logic tick;
  logic signed [20:0] diff;
  logic signed [20:0] step;

  assign bypass = (filter_time == '0);
  assign pre_end = (pre_reg == dio_pkg::PRESCALE_W'(dio_pkg::PRESCALE_CYC - 1));
  assign tick = !bypass && pre_end && (unit_reg >= filter_time - 16'h0001);
  assign diff = $signed({1'b0, sample_reg, 8'h00}) - $signed({1'b0, acc_reg});
  assign step = diff >>> dio_pkg::FILTER_SHIFT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= '0;
    end else if (sample_valid) begin
      sample_reg <= sample;
    end
  end

  // Updates every filter_time * 2^-8 units so the time constant equals filter_time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      unit_reg <= '0;
    end else if (bypass) begin
      pre_reg <= '0;
      unit_reg <= '0;
    end else if (pre_end) begin
      pre_reg <= '0;
      unit_reg <= tick ? '0 : unit_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= tick || (bypass && sample_valid);
      if (bypass && sample_valid) begin
        acc_reg <= {sample, 8'h00};
      end else if (tick) begin
        acc_reg <= 20'($signed({1'b0, acc_reg}) + step);
      end
    end
  end

  assign filtered = acc_reg[19:8];
  assign filtered_valid = valid_reg;
endmodule // dio_lowpass

// File: design/dio_divider.sv
// Unsigned restoring divider, one quotient bit per clock.
// Assumes start is only pulsed while busy is low and den is not zero.
`timescale 1ns/1ps
module dio_divider (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Operands.
  input wire logic start,
  input wire logic [dio_pkg::NUM_W-1:0] num,
  input wire logic [11:0] den,
  // Result.
  output logic busy,
  output logic done,
  output logic [dio_pkg::NUM_W-1:0] quot
);
  logic [dio_pkg::NUM_W-1:0] q_reg;
  logic [11:0] den_reg;
  logic [12:0] rem_reg;
  logic [4:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [12:0] rem_shift;
  logic fits;

  assign rem_shift = {rem_reg[11:0], q_reg[dio_pkg::NUM_W-1]};
  assign fits = (rem_shift >= {1'b0, den_reg});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
      den_reg <= '0;
      rem_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        q_reg <= num;
        den_reg <= den;
        rem_reg <= '0;
        cnt_reg <= 5'(dio_pkg::NUM_W - 1);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg <= fits ? rem_shift - {1'b0, den_reg} : rem_shift;
        q_reg <= {q_reg[dio_pkg::NUM_W-2:0], fits};
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg == '0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign quot = q_reg;
endmodule // dio_divider

// File: testbench/dio_checker.sv
// Port assertions for the drive I/O conditioning top.
// Assumes the field contacts are held open while reset is applied.
`timescale 1ns/1ps
module dio_checker (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic NRST,
  // Inputs that cause the watched outputs.
  input wire logic RUN_INTERLOCK_FIRST,
  input wire logic RUN_INTERLOCK_SECOND,
  input wire logic RUN_PERMISSION_INPUT,
  input wire logic START_REQUEST,
  input wire logic [dio_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_READ,
  // Watched outputs.
  input wire logic START_GRANT,
  input wire logic START_PERMIT,
  input wire logic STOP_REQUEST,
  input wire logic COAST_STOP,
  input wire logic [dio_pkg::DATA_W-1:0] FREQ_REF,
  input wire logic FREQ_REF_VALID,
  input wire logic FIRST_RELAY_OUTPUT,
  input wire logic [dio_pkg::DATA_W-1:0] REG_RDATA
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Contacts take two sync edges and one output edge to show.
  property p_permit_all;
    START_PERMIT |-> $past(RUN_INTERLOCK_FIRST, 3) && $past(RUN_INTERLOCK_SECOND, 3)
      && $past(RUN_PERMISSION_INPUT, 3);
  endproperty
  a_permit_all: assert property (p_permit_all) else $error("permit with a contact open");
  property p_second_open;
    (!RUN_INTERLOCK_SECOND) [*3] |=> !START_PERMIT;
  endproperty
  a_second_open: assert property (p_second_open) else $error("second interlock ignored");
  property p_grant;
    START_GRANT |-> START_PERMIT && $past(START_REQUEST);
  endproperty
  a_grant: assert property (p_grant) else $error("start granted without cause");
  property p_stop_open;
    STOP_REQUEST |-> !$past(RUN_PERMISSION_INPUT, 3);
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("stop with run enable closed");
  property p_run_closed;
    RUN_PERMISSION_INPUT [*3] |=> !STOP_REQUEST;
  endproperty
  a_run_closed: assert property (p_run_closed) else $error("stop kept after enable");
  property p_coast;
    COAST_STOP |-> STOP_REQUEST;
  endproperty
  a_coast: assert property (p_coast) else $error("coast without enable loss");
  property p_ref_hold;
    !FREQ_REF_VALID |-> $stable(FREQ_REF);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference moved without strobe");
  property p_rd_idle;
    !$past(REG_READ) |-> REG_RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_unmapped;
    $past(REG_READ) && $past(REG_ADDR) > 4'h9 |-> REG_RDATA == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  c_grant: cover property (START_GRANT);
  c_ref: cover property (FREQ_REF_VALID);
  c_relay: cover property (FIRST_RELAY_OUTPUT);
endmodule // dio_checker

bind dio_top dio_checker dio_checker_i (.CLOCK, .NRST, .RUN_INTERLOCK_FIRST,
  .RUN_INTERLOCK_SECOND, .RUN_PERMISSION_INPUT, .START_REQUEST, .REG_ADDR, .REG_READ,
  .START_GRANT, .START_PERMIT, .STOP_REQUEST, .COAST_STOP, .FREQ_REF, .FREQ_REF_VALID,
  .FIRST_RELAY_OUTPUT, .REG_RDATA);

// File: testbench/dio_field.sv
// Field side: contacts and an analogue transmitter behind a converter strobe.
// Assumes the bench asks for one sample at a time through take.
`timescale 1ns/1ps
module dio_field (
  // Clock.
  input wire logic clk,
  // Wanted contact states and transmitter level.
  input wire logic [2:0] closed,
  input wire logic [11:0] level,
  input wire logic take,
  // Field pins.
  output logic [2:0] contact,
  output logic [11:0] sample,
  output logic sample_valid
);
  initial begin
    sample = 12'h000;
    sample_valid = 1'b0;
  end
  assign contact = closed;
  always @(posedge clk) begin
    sample_valid <= take;
    // Outside the strobe the code toggles, so a stale code never passes for data.
    sample <= take ? level : ~sample;
  end
endmodule // dio_field

// File: testbench/testbench.sv
// Self-checking bench for the drive I/O conditioning top.
// Assumes the field model and the bound checker are compiled beside it.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] closed = 3'h0;
  logic [11:0] level = 12'h000;
  logic take = 1'b0;
  logic start_req = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_seen = 1'b0;
  logic watch = 1'b0;
  dio_pkg::dio_status_t st = '0;
  logic [2:0] contact;
  logic [11:0] sample;
  logic sample_valid, grant, permit, stop, coast, rvalid, relay;
  logic [15:0] fref, rdata;
  logic [15:0] rd_q[$];
  logic [15:0] fr_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 32'hF087D9B8;
  initial forever #10 clk = ~clk;
  dio_field dio_field_i (.clk(clk), .closed(closed), .level(level), .take(take),
    .contact(contact), .sample(sample), .sample_valid(sample_valid));
  dio_top dio_top_i (.CLOCK(clk), .NRST(nrst), .RUN_INTERLOCK_FIRST(contact[0]),
    .RUN_INTERLOCK_SECOND(contact[1]), .RUN_PERMISSION_INPUT(contact[2]),
    .FIRST_ANALOG_INPUT(sample), .FIRST_ANALOG_VALID(sample_valid), .DRIVE_STATUS(st),
    .START_REQUEST(start_req), .START_GRANT(grant), .START_PERMIT(permit),
    .STOP_REQUEST(stop), .COAST_STOP(coast), .FREQ_REF(fref), .FREQ_REF_VALID(rvalid),
    .FIRST_RELAY_OUTPUT(relay), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr_s),
    .REG_READ(rd_s), .REG_RDATA(rdata));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One bus cycle: a write, or a read whose expected data is queued.
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    if (!w) rd_q.push_back(d);
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  // Spacing of 60 cycles leaves room for the divide path between samples.
  task automatic shoot(input logic [11:0] c);
    @(posedge clk);
    level <= c;
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  function automatic int exp_freq(int code, int rng, int inv, int lo, int hi);
    int pm;
    int pct;
    pm = (code * 16004) >>> 16;
    if (rng != 0) pm = (pm < 200) ? 0 : (pm - 200) * 5 / 4;
    pct = (pm <= lo) ? 0 : ((pm - lo) * 1024) / (hi - lo);
    if (pct > 1024) pct = 1024;
    if (inv != 0) pct = 1024 - pct;
    return 100 + ((1000 * pct) >>> 10);
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out;
    end
    if (rd_seen) cmp("read data", rd_q.pop_front(), rdata);
    if (rvalid && watch) cmp("frequency ref", fr_q.pop_front(), fref);
    rd_seen <= rd_s;
  end
  initial begin
    logic [15:0] rv[16];
    logic [31:0] s;
    logic [12:0] v;
    int lo;
    int hi;
    int code;
    rv = '{0, 0, 0, 16'h03E8, 0, 16'h1388, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b1, 4'h9, 16'hFFFF);
    for (int a = 0; a < 16; a++) acc(1'b0, a[3:0], rv[a]);
    for (int c = 0; c < 9; c++) begin
      s = $random(seed);
      if (c == 8) acc(1'b1, dio_pkg::REG_CTRL, 16'h0004);
      closed <= (c == 8) ? 3'h3 : c[2:0];
      start_req <= s[0];
      repeat (5) @(posedge clk);
      cmp("permit", {15'h0, c == 7}, {15'h0, permit});
      cmp("grant", {15'h0, c == 7 && s[0]}, {15'h0, grant});
      cmp("stop", {15'h0, c < 4 || c == 8}, {15'h0, stop});
      cmp("coast", {15'h0, c == 8}, {15'h0, coast});
    end
    acc(1'b0, dio_pkg::REG_STATUS, 16'h0023);
    for (int i = 0; i < 28; i++) begin
      s = $random(seed);
      st <= {s[9:0], 16'h03E8 + 16'(s[13:10]), 16'h03E8};
      v = {s[0], s[1], s[2], s[3], s[4], s[8] && s[13:10] <= 4'hA, s[5], s[6], !s[7],
        s[7], s[8], s[9], 1'b0};
      acc(1'b1, dio_pkg::REG_RELAY_SEL, 16'(i % 14));
      repeat (4) @(posedge clk);
      cmp("relay", {15'h0, (i % 14 < 13) && v[i % 14]}, {15'h0, relay});
    end
    acc(1'b1, dio_pkg::REG_FREQ_MIN, 16'h0064);
    acc(1'b1, dio_pkg::REG_FREQ_MAX, 16'h044C);
    watch <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      lo = (i % 4 == 1) ? -1600 : ((i % 4 == 2) ? 400 : 0);
      hi = (i % 4 == 1) ? 1600 : ((i % 4 == 2) ? 800 : 1000);
      s = $random(seed);
      code = (i % 4 == 3) ? (i[3] ? 4095 : 0) : int'(s[11:0]);
      if (i == 16) code = 0;
      acc(1'b1, dio_pkg::REG_CTRL, (i == 16) ? 16'h0000 : {14'h0, i[3], i[2]});
      acc(1'b1, dio_pkg::REG_CUSTOM_LOW, 16'(lo));
      acc(1'b1, dio_pkg::REG_CUSTOM_HIGH, 16'(hi));
      fr_q.push_back(16'(exp_freq(code, (i == 16) ? 0 : i / 4 % 2, i / 8 % 2, lo, hi)));
      shoot(code[11:0]);
    end
    watch <= 1'b0;
    acc(1'b1, dio_pkg::REG_FILTER_TIME, 16'h0001);
    shoot(12'hFFF);
    for (int n = 0; n < 2100 && rvalid !== 1'b1; n++) @(posedge clk);
    cmp("filtered step", 16'h0001, {15'h0, fref > 16'h0064 && fref < 16'h044C});
    acc(1'b1, dio_pkg::REG_FILTER_TIME, 16'h0000);
    acc(1'b1, dio_pkg::REG_CUSTOM_LOW, 16'h8000);
    acc(1'b0, dio_pkg::REG_CUSTOM_LOW, 16'hF9C0);
    acc(1'b1, dio_pkg::REG_CUSTOM_HIGH, 16'h7FFF);
    acc(1'b0, dio_pkg::REG_CUSTOM_HIGH, 16'h0640);
    repeat (10) @(posedge clk);
    cmp("pending refs", 16'h0000, 16'(fr_q.size()));
    close_out;
  end
endmodule // testbench
